// ### tb/uwsu_mem_model.sv
// Memory system model that accepts partial store requests
`timescale 1ns/1ns
module uwsu_mem_model
    import uwsu_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Store port
    input wire logic store_valid,
    input wire uwsu_store_req_t store_req,
    output logic store_ready,
    // Bench control and view
    input wire logic [2:0] stall,
    output logic [63:0] mem_q
);
// ----------------------------------------------------------------
// Acceptance and lane update
// ----------------------------------------------------------------
logic [2:0] wait_q;
logic [3:0] lo;
// Little-endian lanes only: right stores end at the word top, left start at the offset
assign lo = store_req.kind_swr ? {1'b0, store_req.byte_offset} + 4'h3
    - store_req.transfer_size_code : {1'b0, store_req.byte_offset};
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        store_ready <= 1'b0;
        wait_q <= 3'h0;
        mem_q <= 64'h0;
    end
    else if (store_ready)
    begin
        store_ready <= 1'b0;
        wait_q <= 3'h0;
        for (int i = 0; i < 8; i++)
            if (i >= lo && i <= lo + store_req.transfer_size_code)
                mem_q[8*i +: 8] <= store_req.data[8*i +: 8];
    end
    else if (store_valid && wait_q == stall)
        store_ready <= 1'b1;
    else if (store_valid)
        wait_q <= wait_q + 3'h1;
end
endmodule // uwsu_mem_model

// ### tb/uwsu_top_tb.sv
// Self-checking bench for the unaligned word store unit
`timescale 1ns/1ns
module uwsu_top_tb;
import uwsu_pkg::*;
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
// ----------------------------------------------------------------
// Signals and instances
// ----------------------------------------------------------------
logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, er;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0, prdata, rd;
logic issue_valid = 0, issue_ready, xlate_valid, xlate_done = 0, store_valid, store_ready;
uwsu_issue_t issue = '0;
uwsu_xlate_req_t xlate_req;
uwsu_xlate_rsp_t xlate_rsp = '0;
uwsu_store_req_t store_req;
logic [2:0] stall = 3'h0, cfg = 3'h0;
logic [63:0] mem;
int n_fail = 0, n_checks = 0, n_st = 0;
always #20 pclk = ~pclk;
uwsu_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .issue_valid(issue_valid), .issue(issue), .issue_ready(issue_ready),
    .xlate_valid(xlate_valid), .xlate_req(xlate_req), .xlate_done(xlate_done),
    .xlate_rsp(xlate_rsp), .store_valid(store_valid), .store_req(store_req),
    .store_ready(store_ready), .irq(irq));
uwsu_mem_model u_mem (.pclk(pclk), .presetn(presetn), .store_valid(store_valid),
    .store_req(store_req), .store_ready(store_ready), .stall(stall), .mem_q(mem));
task results;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask
// Bounded wait, returns at the falling edge before the sampling edge
task wt(input int k);
    for (int i = 0; i < 100; i++)
    begin
        @(negedge pclk);
        if (k == 0 ? issue_ready : k == 1 ? xlate_valid : k == 2 ? store_valid : pready)
            return;
    end
    n_fail++;
    $display("[FAIL] wait %0d exp 1 got 0", k);
    results;
endtask
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    wt(3);
    rd = prdata;
    er = pslverr;
    @(posedge pclk);
    psel <= 0;
    penable <= 0;
endtask
task give(input logic [5:0] op, input logic [63:0] base, input logic [15:0] off,
    input logic [31:0] src);
    @(posedge pclk);
    issue <= '{base_value: base, source_value: {~src, src}, instr: {op, 5'h3, 5'h4, off}};
    issue_valid <= 1;
    wt(0);
    @(posedge pclk);
    issue_valid <= 0;
endtask
task run(input logic store_word_right, input logic [63:0] base, input logic [15:0] off,
    input logic [31:0] src);
    logic [63:0] va, pa, dat;
    logic [31:0] w;
    logic [1:0] b;
    va = base + {{48{off[15]}}, off};
    pa = va ^ 64'h1000 ^ {61'h0, {3{cfg[2]}}};
    if (!cfg[0])
        pa[1:0] = 2'h0;
    b = va[1:0] ^ {2{cfg[1]}};
    w = store_word_right ? src << (8 * b) : src >> (24 - 8 * b);
    dat = (va[2] ^ cfg[1]) ? {w, 32'h0} : {32'h0, w};
    stall <= off[1:0];
    give(store_word_right ? 6'h2E : 6'h2A, base, off, src);
    wt(1);
    `CHK("virtual_addr", va, xlate_req.virtual_addr)
    @(posedge pclk);
    xlate_done <= 1;
    xlate_rsp <= '{phys_addr: va ^ 64'h1000, uncached: store_word_right};
    @(posedge pclk);
    xlate_done <= 0;
    wt(2);
    `CHK("paddr", pa, store_req.phys_addr)
    `CHK("uncached", store_word_right, store_req.uncached)
    `CHK("data", dat, store_req.data)
    `CHK("size", store_word_right ? 2'h3 - b : b, store_req.transfer_size_code)
    `CHK("offset", pa[2:0], store_req.byte_offset)
    wt(0);
    n_st++;
endtask
// ----------------------------------------------------------------
// Scenarios
// ----------------------------------------------------------------
task t_regs;
    apb(0, UWSU_A_CTRL, 0);
    `CHK("ctrl", 32'h0, rd)
    apb(0, 8'h24, 0);
    `CHK("unmapped", 1'b1, er)
    $display("test regs done");
endtask
task t_stores;
    for (int c = 0; c < 8; c++)
    begin
        cfg = c;
        apb(1, UWSU_A_CTRL, {29'h0, cfg});
        for (int k = 0; k < 16; k++)
            run(k[3], 64'h2000, 16'hFFF8 + k[2:0], 32'hA1B2C3D4);
    end
    $display("test stores done");
endtask
task t_pair;
    logic [63:0] m0;
    cfg = 0;
    apb(1, UWSU_A_CTRL, 0);
    m0 = mem;
    run(1, 64'h2000, 16'hFFFA, 32'h11223344);
    run(0, 64'h2000, 16'hFFFD, 32'h11223344);
    `CHK("pair", 32'h11223344, mem[47:16])
    `CHK("rest", {m0[63:48], m0[15:0]}, {mem[63:48], mem[15:0]})
    $display("test pair done");
endtask
task t_irq;
    apb(0, UWSU_A_COUNT, 0);
    `CHK("count", n_st[31:0], rd)
    give(6'h2B, 64'h0, 16'h0, 32'h0);
    wt(0);
    apb(0, UWSU_A_STAT, 0);
    `CHK("status", 2'h3, rd[1:0])
    `CHK("irq masked", 1'b0, irq)
    apb(1, UWSU_A_MASK, 2);
    repeat (2) @(negedge pclk);
    `CHK("irq set", 1'b1, irq)
    apb(1, UWSU_A_STAT, 2);
    repeat (2) @(negedge pclk);
    `CHK("irq clear", 1'b0, irq)
    apb(0, UWSU_A_STAT, 0);
    `CHK("status w1c", 2'h1, rd[1:0])
    $display("test irq done");
endtask
initial
begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_stores;
    t_pair;
    t_irq;
    results;
end
endmodule // uwsu_top_tb

// ### verilog/uwsu_addr_former.sv
// Effective address forming for the partial word stores
`timescale 1ns/1ns
module uwsu_addr_former
    import uwsu_pkg::*;
(
    // Operands
    input wire logic [63:0] base_value,
    input wire logic [15:0] offset,
    // Result
    output logic [63:0] virtual_addr
);

    // No alignment check: any byte address is legal here
    assign virtual_addr = base_value + {{48{offset[15]}}, offset};

endmodule // uwsu_addr_former

// ### verilog/uwsu_lane_former.sv
// Byte lane and size forming for the partial word stores
`timescale 1ns/1ns
module uwsu_lane_former
    import uwsu_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request in
    input wire logic in_valid,
    input wire logic kind_swr,
    input wire logic [63:0] virtual_addr,
    input wire logic [63:0] phys_addr,
    input wire logic uncached,
    input wire logic [31:0] source_word,
    input wire uwsu_cfg_t cfg,
    // Formed request out
    output uwsu_store_req_t req,
    output logic req_valid
);

    typedef struct packed {
        uwsu_store_req_t req;
        logic valid;
    } uwsu_lf_state_t;

    uwsu_lf_state_t s_q;
    uwsu_lf_state_t s_d;

    always_comb
    begin
        logic [1:0] byte_idx;
        logic upper_half;
        logic [63:0] pa;
        logic [31:0] lane;
        byte_idx = 2'h0;
        upper_half = 1'b0;
        pa = 64'h0;
        lane = 32'h0;
        s_d = s_q;
        s_d.valid = in_valid;
        if (in_valid)
        begin
            pa = {phys_addr[63:3], phys_addr[2:0] ^ {3{cfg.user_byte_order_flip}}};
            if (!cfg.memory_big_endian_flag)
            begin
                pa[1:0] = 2'h0;
            end
            byte_idx = virtual_addr[1:0] ^ {2{cfg.cpu_big_endian_flag}};
            upper_half = virtual_addr[2] ^ cfg.cpu_big_endian_flag;
            if (kind_swr)
            begin
                lane = source_word << {byte_idx, 3'h0};
                s_d.req.transfer_size_code = UWSU_WORD_CODE - byte_idx;
            end
            else
            begin
                lane = source_word >> {~byte_idx, 3'h0};
                s_d.req.transfer_size_code = byte_idx;
            end
            s_d.req.data = upper_half ? {lane, 32'h0} : {32'h0, lane};
            s_d.req.phys_addr = pa;
            s_d.req.byte_offset = pa[2:0];
            s_d.req.virtual_addr = virtual_addr;
            s_d.req.uncached = uncached;
            s_d.req.kind_swr = kind_swr;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign req = s_q.req;
    assign req_valid = s_q.valid;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_swr_size_code: assert property (@(posedge pclk) disable iff (!presetn)
        (in_valid && kind_swr) |=> (req.transfer_size_code == 2'h3
            - $past(virtual_addr[1:0] ^ {2{cfg.cpu_big_endian_flag}})))
        else $error("store right size code wrong");
    chk_swl_size_code: assert property (@(posedge pclk) disable iff (!presetn)
        (in_valid && !kind_swr) |=> (req.transfer_size_code
            == $past(virtual_addr[1:0] ^ {2{cfg.cpu_big_endian_flag}})))
        else $error("store left size code wrong");
    chk_le_offset_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (in_valid && !cfg.memory_big_endian_flag) |=> (req.byte_offset[1:0] == 2'h0))
        else $error("little endian offset low bits not zero");
    chk_half_select: assert property (@(posedge pclk) disable iff (!presetn)
        (in_valid && (virtual_addr[2] ^ cfg.cpu_big_endian_flag)) |=> (req.data[31:0] == 32'h0))
        else $error("upper half store touched lower half");
    chk_swr_low_byte: assert property (@(posedge pclk) disable iff (!presetn)
        (in_valid && kind_swr && virtual_addr[2:0] == 3'h0 && !cfg.cpu_big_endian_flag)
        |=> (req.data[7:0] == $past(source_word[7:0])))
        else $error("store right low byte misplaced");
    chk_swl_top_byte: assert property (@(posedge pclk) disable iff (!presetn)
        (in_valid && !kind_swr && virtual_addr[2:0] == 3'h4 && !cfg.cpu_big_endian_flag)
        |=> (req.data[39:32] == $past(source_word[31:24]) && req.transfer_size_code == 2'h0))
        else $error("store left top byte misplaced");
    chk_flip_offset: assert property (@(posedge pclk) disable iff (!presetn)
        (in_valid && cfg.memory_big_endian_flag)
        |=> (req.byte_offset == $past(phys_addr[2:0] ^ {3{cfg.user_byte_order_flip}})))
        else $error("flip not applied to offset");
    cov_swl_le: cover property (@(posedge pclk) disable iff (!presetn)
        in_valid && !kind_swr && !cfg.memory_big_endian_flag);
    cov_swr_be: cover property (@(posedge pclk) disable iff (!presetn)
        in_valid && kind_swr && cfg.cpu_big_endian_flag);
    cov_flip: cover property (@(posedge pclk) disable iff (!presetn)
        in_valid && cfg.user_byte_order_flip);

endmodule // uwsu_lane_former

// ### verilog/uwsu_pkg.sv
// Shared types and constants for the unaligned word store unit
package uwsu_pkg;

    // ----------------------------------------------------------------
    // Instruction encoding
    // ----------------------------------------------------------------
    localparam logic [5:0] UWSU_OP_SWL = 6'h2A;
    localparam logic [5:0] UWSU_OP_SWR = 6'h2E;
    localparam int UWSU_OP_HI = 31;
    localparam int UWSU_OP_LO = 26;
    localparam int UWSU_BASE_HI = 25;
    localparam int UWSU_BASE_LO = 21;
    localparam int UWSU_SRC_HI = 20;
    localparam int UWSU_SRC_LO = 16;
    localparam int UWSU_OFF_HI = 15;
    localparam int UWSU_OFF_LO = 0;
    localparam logic [1:0] UWSU_WORD_CODE = 2'h3;

    // ----------------------------------------------------------------
    // Register map (APB byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] UWSU_A_CTRL = 8'h00;
    localparam logic [7:0] UWSU_A_STAT = 8'h04;
    localparam logic [7:0] UWSU_A_MASK = 8'h08;
    localparam logic [7:0] UWSU_A_COUNT = 8'h0C;
    localparam logic [7:0] UWSU_A_LAST_ADDR = 8'h10;
    localparam logic [7:0] UWSU_A_LAST_DATA_LO = 8'h14;
    localparam logic [7:0] UWSU_A_LAST_DATA_HI = 8'h18;
    localparam logic [7:0] UWSU_A_LAST_INFO = 8'h1C;
    localparam int UWSU_CTRL_MEM_BE = 0;
    localparam int UWSU_CTRL_CPU_BE = 1;
    localparam int UWSU_CTRL_FLIP = 2;
    localparam logic [2:0] UWSU_CTRL_RESET = 3'h0;
    localparam int UWSU_EV_STORE = 0;
    localparam int UWSU_EV_REFUSE = 1;
    localparam int UWSU_EV_W = 2;
    localparam logic [UWSU_EV_W-1:0] UWSU_EV_RESET = 2'h0;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {UWSU_KIND_SWL, UWSU_KIND_SWR} uwsu_kind_t;

    typedef struct packed {
        logic [63:0] base_value;
        logic [63:0] source_value;
        logic [31:0] instr;
    } uwsu_issue_t;

    typedef struct packed {
        logic [63:0] virtual_addr;
        logic kind_swr;
    } uwsu_xlate_req_t;

    typedef struct packed {
        logic [63:0] phys_addr;
        logic uncached;
    } uwsu_xlate_rsp_t;

    typedef struct packed {
        logic [63:0] phys_addr;
        logic [63:0] virtual_addr;
        logic [63:0] data;
        logic [1:0] transfer_size_code;
        logic [2:0] byte_offset;
        logic uncached;
        logic kind_swr;
    } uwsu_store_req_t;

    typedef struct packed {
        logic memory_big_endian_flag;
        logic cpu_big_endian_flag;
        logic user_byte_order_flip;
    } uwsu_cfg_t;

endpackage

// ### verilog/uwsu_top.sv
// Unaligned word store unit: decode, translate, form and issue
`timescale 1ns/1ns
module uwsu_top
    import uwsu_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Instruction issue
    input wire logic issue_valid,
    input wire uwsu_issue_t issue,
    output logic issue_ready,
    // Address translation
    output logic xlate_valid,
    output uwsu_xlate_req_t xlate_req,
    input wire logic xlate_done,
    input wire uwsu_xlate_rsp_t xlate_rsp,
    // Store request to memory
    output logic store_valid,
    output uwsu_store_req_t store_req,
    input wire logic store_ready,
    // Interrupt
    output logic irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {UWSU_IDLE, UWSU_XLATE, UWSU_FORM, UWSU_SEND} uwsu_fsm_t;

    typedef struct packed {
        uwsu_fsm_t fsm;
        uwsu_cfg_t cfg;
        logic [UWSU_EV_W-1:0] status;
        logic [UWSU_EV_W-1:0] mask;
        logic [31:0] count;
        logic kind_swr;
        logic [63:0] virtual_addr;
        logic [31:0] source_word;
        uwsu_xlate_rsp_t xr;
        uwsu_store_req_t out;
        logic out_valid;
        logic issue_ready;
        logic xlate_valid;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } uwsu_state_t;

    uwsu_state_t s_q;
    uwsu_state_t s_d;

    logic [63:0] ea;
    uwsu_store_req_t formed;
    logic formed_valid;
    logic is_swl;
    logic is_swr;

    // Opcode match, used by both issue check and state update
    function automatic logic [1:0] uwsu_decode(input logic [31:0] instr);
        logic [5:0] op;
        op = instr[UWSU_OP_HI:UWSU_OP_LO];
        uwsu_decode = {op == UWSU_OP_SWR, op == UWSU_OP_SWL};
    endfunction

    assign {is_swr, is_swl} = uwsu_decode(issue.instr);

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    uwsu_addr_former u_addr
    (
        .base_value(issue.base_value),
        .offset(issue.instr[UWSU_OFF_HI:UWSU_OFF_LO]),
        .virtual_addr(ea)
    );

    uwsu_lane_former u_lane
    (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(s_q.fsm == UWSU_FORM),
        .kind_swr(s_q.kind_swr),
        .virtual_addr(s_q.virtual_addr),
        .phys_addr(s_q.xr.phys_addr),
        .uncached(s_q.xr.uncached),
        .source_word(s_q.source_word),
        .cfg(s_q.cfg),
        .req(formed),
        .req_valid(formed_valid)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [UWSU_EV_W-1:0] ev;
        logic [UWSU_EV_W-1:0] clr;
        logic acc;
        ev = '0;
        clr = '0;
        acc = 1'b0;
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        unique case (s_q.fsm)
            UWSU_IDLE:
            begin
                s_d.issue_ready = 1'b1;
                if (issue_valid && s_q.issue_ready)
                begin
                    if (is_swl || is_swr)
                    begin
                        s_d.kind_swr = is_swr;
                        s_d.virtual_addr = ea;
                        s_d.source_word = issue.source_value[31:0];
                        s_d.issue_ready = 1'b0;
                        s_d.xlate_valid = 1'b1;
                        s_d.fsm = UWSU_XLATE;
                    end
                    else
                    begin
                        ev[UWSU_EV_REFUSE] = 1'b1;
                    end
                end
            end
            UWSU_XLATE:
            begin
                if (xlate_done)
                begin
                    s_d.xlate_valid = 1'b0;
                    s_d.xr = xlate_rsp;
                    s_d.fsm = UWSU_FORM;
                end
            end
            UWSU_FORM:
            begin
                // The lane former registers its result one cycle later
                s_d.fsm = UWSU_SEND;
            end
            UWSU_SEND:
            begin
                if (formed_valid)
                begin
                    s_d.out = formed;
                    s_d.out_valid = 1'b1;
                end
                if (s_q.out_valid && store_ready)
                begin
                    s_d.out_valid = 1'b0;
                    s_d.count = s_q.count + 32'h1;
                    ev[UWSU_EV_STORE] = 1'b1;
                    s_d.issue_ready = 1'b1;
                    s_d.fsm = UWSU_IDLE;
                end
            end
        endcase

        // APB: single-wait-state slave, answer one cycle after access starts
        acc = psel && penable && !s_q.pready;
        if (acc)
        begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h0;
            if (pwrite)
            begin
                unique case (paddr)
                    UWSU_A_CTRL:
                    begin
                        // Field positions follow the package, not the struct order
                        s_d.cfg.memory_big_endian_flag = pwdata[UWSU_CTRL_MEM_BE];
                        s_d.cfg.cpu_big_endian_flag = pwdata[UWSU_CTRL_CPU_BE];
                        s_d.cfg.user_byte_order_flip = pwdata[UWSU_CTRL_FLIP];
                    end
                    UWSU_A_STAT: clr = pwdata[UWSU_EV_W-1:0];
                    UWSU_A_MASK: s_d.mask = pwdata[UWSU_EV_W-1:0];
                    UWSU_A_COUNT, UWSU_A_LAST_ADDR, UWSU_A_LAST_DATA_LO,
                    UWSU_A_LAST_DATA_HI, UWSU_A_LAST_INFO: s_d.pslverr = 1'b0;
                    default: s_d.pslverr = 1'b1;
                endcase
            end
            else
            begin
                unique case (paddr)
                    UWSU_A_CTRL: s_d.prdata = {29'h0, s_q.cfg.user_byte_order_flip,
                        s_q.cfg.cpu_big_endian_flag, s_q.cfg.memory_big_endian_flag};
                    UWSU_A_STAT: s_d.prdata = {30'h0, s_q.status};
                    UWSU_A_MASK: s_d.prdata = {30'h0, s_q.mask};
                    UWSU_A_COUNT: s_d.prdata = s_q.count;
                    UWSU_A_LAST_ADDR: s_d.prdata = s_q.out.phys_addr[31:0];
                    UWSU_A_LAST_DATA_LO: s_d.prdata = s_q.out.data[31:0];
                    UWSU_A_LAST_DATA_HI: s_d.prdata = s_q.out.data[63:32];
                    UWSU_A_LAST_INFO: s_d.prdata = {25'h0, s_q.out.kind_swr,
                        s_q.out.uncached, s_q.out.byte_offset, s_q.out.transfer_size_code};
                    default: s_d.pslverr = 1'b1;
                endcase
            end
        end

        // Set wins over write-one-to-clear
        s_d.status = (s_q.status & ~clr) | ev;
        s_d.irq = |(s_d.status & s_q.mask);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign issue_ready = s_q.issue_ready;
    assign xlate_valid = s_q.xlate_valid;
    assign xlate_req = '{virtual_addr: s_q.virtual_addr, kind_swr: s_q.kind_swr};
    assign store_valid = s_q.out_valid;
    assign store_req = s_q.out;
    assign irq = s_q.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_decode_swr: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.fsm == UWSU_IDLE && s_q.issue_ready && issue_valid
            && issue.instr[31:26] == 6'h2E) |=> (s_q.fsm == UWSU_XLATE && s_q.kind_swr))
        else $error("store right not decoded");
    chk_ea_sum: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.fsm == UWSU_IDLE && s_q.issue_ready && issue_valid && (is_swl || is_swr))
        |=> (s_q.virtual_addr == $past(issue.base_value)
            + {{48{$past(issue.instr[15])}}, $past(issue.instr[15:0])}))
        else $error("effective address wrong");
    chk_no_align_err: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.fsm == UWSU_IDLE && s_q.issue_ready && issue_valid && (is_swl || is_swr))
        |=> !s_q.status[UWSU_EV_REFUSE] || $past(s_q.status[UWSU_EV_REFUSE]))
        else $error("partial store flagged as refused");
    chk_xlate_first: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(store_valid) |-> $past(s_q.fsm == UWSU_FORM, 2) || $past(xlate_done, 3))
        else $error("store issued before translation");
    chk_store_half: assert property (@(posedge pclk) disable iff (!presetn)
        store_valid |-> (store_req.data[63:32] == 32'h0 || store_req.data[31:0] == 32'h0))
        else $error("store spans two words");
    chk_store_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (store_valid && !store_ready) |=> (store_valid && $stable(store_req)))
        else $error("store request dropped while stalled");
    chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready)
        else $error("apb answer late");
    chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (irq == $past(|(s_d.status & s_q.mask)))) else $error("irq mismatch");
    cov_store_done: cover property (@(posedge pclk) disable iff (!presetn)
        store_valid && store_ready);
    cov_stall: cover property (@(posedge pclk) disable iff (!presetn)
        store_valid && !store_ready ##1 store_valid && store_ready);
    cov_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));

endmodule // uwsu_top
